// >>> logic/lbf_pkg.sv
/*
 * Shared constants and carriers for the ladder branch and flow-control unit:
 * program address width, temporary condition bit count, skip numbering,
 * instruction opcodes and the packed request and issue structs.
 * Assumes the fetch side presents one decoded instruction word per step.
 */
package lbf_pkg;

	// Program address and stepping
	localparam int PROG_AW = 16;
	localparam logic [PROG_AW-1:0] PC_RESET = 16'h0000;
	localparam logic [PROG_AW-1:0] PC_STEP = 16'h0001;

	// Temporary condition bits
	localparam int TEMP_BITS = 8;
	localparam int TEMP_IW = 3;
	localparam logic [TEMP_BITS-1:0] TEMP_RESET = 8'h00;

	// Skip numbering: 00 is the shared searching kind, 01..99 are table driven
	localparam int SKIP_NW = 7;
	localparam int SKIP_COUNT = 100;
	localparam logic [SKIP_NW-1:0] SKIP_SHARED = 7'h00;
	localparam logic [SKIP_NW-1:0] SKIP_LAST = 7'h63;

	// Reset levels of the condition path
	localparam logic COND_RESET = 1'b0;
	localparam logic GATE_OPEN = 1'b1;

	// Instruction classes seen by this unit
	typedef enum logic [3:0] {
		OP_LOGIC,
		OP_LOAD_BIT,
		OP_RIGHT,
		OP_STORE_TEMP,
		OP_LOAD_TEMP,
		OP_GATE,
		OP_RELEASE,
		OP_SKIP_START,
		OP_SKIP_END
	} lbf_op_e;

	// One fetched instruction; bit_value is the new line condition for
	// OP_LOGIC and OP_LOAD_BIT, computed by the bit unit
	typedef struct packed {
		lbf_op_e op;
		logic [SKIP_NW-1:0] operand;
		logic bit_value;
	} lbf_instr_s;

	// Instruction issued to the executing units with its final condition
	typedef struct packed {
		logic valid;
		lbf_op_e op;
		logic [SKIP_NW-1:0] operand;
		logic cond;
	} lbf_exec_s;

endpackage : lbf_pkg

// >>> logic/lbf_skip_table.sv
/*
 * Skip-end address table: one program address per skip number,
 * written by the program loader, read with one cycle of latency.
 * Assumes the loader fills it before execution starts.
 */
`timescale 1ns/1ps

module lbf_skip_table (
	input wire logic i_clk_sys,
	input wire logic i_we,
	input wire logic [lbf_pkg::SKIP_NW-1:0] i_wr_num,
	input wire logic [lbf_pkg::PROG_AW-1:0] i_wr_addr,
	input wire logic [lbf_pkg::SKIP_NW-1:0] i_rd_num,
	output logic [lbf_pkg::PROG_AW-1:0] o_rd_addr
);
	import lbf_pkg::*;

	logic [PROG_AW-1:0] mem_reg [SKIP_COUNT];

	// Plain storage with no reset, so it maps onto block memory
	always_ff @(posedge i_clk_sys) begin
		if (i_we && (i_wr_num <= SKIP_LAST)) begin
			mem_reg[i_wr_num] <= i_wr_addr;
		end
		o_rd_addr <= mem_reg[i_rd_num];
	end

endmodule : lbf_skip_table

// >>> logic/lbf_flow_ctrl.sv
/*
 * Execution-flow unit of a ladder program executor: temporary condition
 * bits, section gating and skips over program sections.
 * Assumes i_instr is the word at o_fetch_addr whenever i_instr_valid is
 * high, and that the bit unit folds o_cond into OP_LOGIC results.
 */
`timescale 1ns/1ps

//
// Behaviour
// - Exactly eight temporary condition bits, indexed zero to seven.
// - Storing to a temporary bit copies the current execution condition.
// - Loading a temporary bit replaces the condition with the saved value.
// - A saved temporary bit may be reloaded any number of times.
// - Each return to the left rail starts a new instruction block.
// - Section gate condition governs everything up to the next release.
// - Gate OFF runs every right-hand instruction with OFF condition.
// - Gate ON lets each line use its own condition, equal to ANDing.
// - After release, ordinary execution resumes with the next line.
// - Several gates before one release; inner gates only restrict.
// - Skip start with ON condition executes following code normally.
// - Skip start OFF moves to skip end, executing and changing nothing.
// - Skip instructions carry number 00 to 99, selecting skip kind.
// - Numbered OFF skip transfers straight to the matching skip end.
// - Skip 00 starts may repeat, even consecutively, sharing one end.
// - Skip 00 OFF searches forward for next end 00, continues after.

module lbf_flow_ctrl (
	input wire logic i_clk_sys,
	input wire logic i_reset,
	input wire logic i_scan_restart,
	input wire logic i_instr_valid,
	input wire lbf_pkg::lbf_instr_s i_instr,
	input wire logic i_tbl_we,
	input wire logic [lbf_pkg::SKIP_NW-1:0] i_tbl_num,
	input wire logic [lbf_pkg::PROG_AW-1:0] i_tbl_addr,
	output logic [lbf_pkg::PROG_AW-1:0] o_fetch_addr,
	output logic o_cond,
	output logic o_gate_open,
	output logic o_busy,
	output lbf_pkg::lbf_exec_s o_exec,
	output logic o_temp_reuse,
	output logic [lbf_pkg::TEMP_BITS-1:0] o_temp_bits
);
	import lbf_pkg::*;

	typedef enum logic [1:0] {
		ST_RUN,
		ST_TABLE_WAIT,
		ST_SEARCH
	} lbf_state_e;

	lbf_state_e state_reg;
	lbf_state_e state_next;
	logic [PROG_AW-1:0] pc_reg;
	logic [PROG_AW-1:0] pc_next;
	logic cond_reg;
	logic cond_next;
	logic gate_reg;
	logic gate_next;
	logic [TEMP_BITS-1:0] temp_reg;
	logic [TEMP_BITS-1:0] temp_next;
	logic [TEMP_BITS-1:0] used_reg;
	logic [TEMP_BITS-1:0] used_next;
	logic busy_reg;
	logic reuse_reg;
	logic reuse_next;
	lbf_exec_s exec_reg;
	lbf_exec_s exec_next;
	logic [PROG_AW-1:0] table_addr;

	// Decode of the current word, only meaningful while running
	wire logic run_step = (state_reg == ST_RUN) && i_instr_valid;
	wire logic [TEMP_IW-1:0] temp_idx = i_instr.operand[TEMP_IW-1:0];
	wire logic [TEMP_BITS-1:0] temp_onehot = TEMP_BITS'(1) << temp_idx;
	wire logic is_store_temp = run_step && (i_instr.op == OP_STORE_TEMP);
	wire logic is_load_temp = run_step && (i_instr.op == OP_LOAD_TEMP);
	wire logic is_load_bit = run_step && (i_instr.op == OP_LOAD_BIT);
	wire logic is_logic = run_step && (i_instr.op == OP_LOGIC);
	wire logic is_right = run_step && (i_instr.op == OP_RIGHT);
	wire logic is_gate = run_step && (i_instr.op == OP_GATE);
	wire logic is_release = run_step && (i_instr.op == OP_RELEASE);
	wire logic is_skip_start = run_step && (i_instr.op == OP_SKIP_START);

	// Gated condition: an OFF gate wins over any line condition
	wire logic eff_cond = cond_reg & gate_reg;
	wire logic skip_shared = (i_instr.operand == SKIP_SHARED);
	wire logic skip_taken = is_skip_start && !eff_cond;
	wire logic skip_by_table = skip_taken && !skip_shared;
	wire logic skip_by_search = skip_taken && skip_shared;
	wire logic search_hit = i_instr_valid && (i_instr.op == OP_SKIP_END)
		&& (i_instr.operand == SKIP_SHARED);
	wire logic [PROG_AW-1:0] pc_inc = pc_reg + PC_STEP;

	// Skip-end addresses; the read is registered, hence the wait state
	lbf_skip_table lbf_skip_table_inst (
		.i_clk_sys(i_clk_sys),
		.i_we(i_tbl_we),
		.i_wr_num(i_tbl_num),
		.i_wr_addr(i_tbl_addr),
		.i_rd_num(i_instr.operand),
		.o_rd_addr(table_addr)
	);

	// Program address and state sequencing
	always_comb begin
		state_next = state_reg;
		pc_next = pc_reg;
		case (state_reg)
			ST_RUN: begin
				if (skip_by_table) begin
					state_next = ST_TABLE_WAIT;
				end else if (skip_by_search) begin
					state_next = ST_SEARCH;
					pc_next = pc_inc;
				end else if (run_step) begin
					pc_next = pc_inc;
				end
			end
			ST_TABLE_WAIT: begin
				// Land on the matching end, which then runs as a no-op
				pc_next = table_addr;
				state_next = ST_RUN;
			end
			ST_SEARCH: begin
				// Walk forward; ends 00 shared by any number of starts
				if (i_instr_valid) begin
					pc_next = pc_inc;
				end
				if (search_hit) begin
					state_next = ST_RUN;
				end
			end
			default: begin
				state_next = ST_RUN;
			end
		endcase
		if (i_scan_restart) begin
			state_next = ST_RUN;
			pc_next = PC_RESET;
		end
	end

	// Line condition: loads and logic results replace it, temps restore it
	always_comb begin
		cond_next = cond_reg;
		if (is_load_bit || is_logic) begin
			cond_next = i_instr.bit_value;
		end else if (is_load_temp) begin
			cond_next = temp_reg[temp_idx];
		end else if (is_gate) begin
			// Lines after a gate carry the gated condition until their own load
			cond_next = eff_cond;
		end
	end

	// Gating flag: OFF gate forces it closed until the release or a scan restart
	always_comb begin
		gate_next = gate_reg;
		if (is_gate && !cond_reg) begin
			gate_next = !GATE_OPEN;
		end else if (is_release) begin
			gate_next = GATE_OPEN;
		end
		if (i_scan_restart) begin
			gate_next = GATE_OPEN;
		end
	end

	// Temporary bits and the per-block usage mask behind the reuse warning
	always_comb begin
		temp_next = temp_reg;
		used_next = used_reg;
		reuse_next = 1'b0;
		if (is_store_temp) begin
			temp_next[temp_idx] = cond_reg;
			used_next = used_reg | temp_onehot;
			reuse_next = |(used_reg & temp_onehot);
		end else if (is_load_bit) begin
			used_next = TEMP_RESET;
		end
	end

	// Issue path: only right-hand work leaves the unit, never while skipping
	always_comb begin
		exec_next = '0;
		if (is_right) begin
			exec_next.valid = 1'b1;
			exec_next.op = i_instr.op;
			exec_next.operand = i_instr.operand;
			exec_next.cond = eff_cond;
		end
	end

	// Control state; async reset loads constants only
	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			state_reg <= ST_RUN;
			pc_reg <= PC_RESET;
			busy_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			pc_reg <= pc_next;
			busy_reg <= (state_next != ST_RUN);
		end
	end

	// Condition path registers
	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			cond_reg <= COND_RESET;
			gate_reg <= GATE_OPEN;
			temp_reg <= TEMP_RESET;
			used_reg <= TEMP_RESET;
		end else begin
			cond_reg <= cond_next;
			gate_reg <= gate_next;
			temp_reg <= temp_next;
			used_reg <= used_next;
		end
	end

	// Registered issue and warning outputs
	always_ff @(posedge i_clk_sys or posedge i_reset) begin
		if (i_reset) begin
			exec_reg <= '0;
			reuse_reg <= 1'b0;
		end else begin
			exec_reg <= exec_next;
			reuse_reg <= reuse_next;
		end
	end

	assign o_fetch_addr = pc_reg;
	assign o_cond = cond_reg;
	assign o_gate_open = gate_reg;
	assign o_busy = busy_reg;
	assign o_exec = exec_reg;
	assign o_temp_reuse = reuse_reg;
	assign o_temp_bits = temp_reg;

endmodule : lbf_flow_ctrl

// >>> verification/lbf_flow_ctrl_checker.sv
/*
 * Port-level assertions for the flow-control unit.
 * Assumes it is bound to lbf_flow_ctrl and sees only its ports.
 */
`timescale 1ns/1ps

module lbf_flow_ctrl_checker
	import lbf_pkg::*;
(
	input wire logic i_clk_sys,
	input wire logic i_reset,
	input wire logic i_scan_restart,
	input wire logic i_instr_valid,
	input wire lbf_pkg::lbf_instr_s i_instr,
	input wire logic [lbf_pkg::PROG_AW-1:0] o_fetch_addr,
	input wire logic o_cond,
	input wire logic o_gate_open,
	input wire logic o_busy,
	input wire lbf_pkg::lbf_exec_s o_exec,
	input wire logic [lbf_pkg::TEMP_BITS-1:0] o_temp_bits
);
	import lbf_pkg::*;

	// A word counts only when the unit is running, not waiting or searching
	wire logic take = i_instr_valid && !o_busy;
	wire logic lit = o_cond & o_gate_open;
	wire lbf_op_e op = i_instr.op;

	default clocking @(posedge i_clk_sys); endclocking
	default disable iff (i_reset);

	right_issue_a:
	assert property (take && op == OP_RIGHT |=> o_exec.valid && o_exec.cond == $past(lit))
		else $error("right-hand issue condition wrong");
	exec_source_a:
	assert property (o_exec.valid |-> $past(take && op == OP_RIGHT))
		else $error("issue without a right-hand word");
	temp_store_a:
	assert property (take && op == OP_STORE_TEMP |=>
		o_temp_bits[$past(i_instr.operand[2:0])] == $past(o_cond))
		else $error("temporary bit store wrong");
	temp_load_a:
	assert property (take && op == OP_LOAD_TEMP |=>
		o_cond == $past(o_temp_bits[i_instr.operand[2:0]]))
		else $error("temporary bit load wrong");
	gate_close_a:
	assert property (take && op == OP_GATE && !lit |=> !o_gate_open)
		else $error("gate did not close");
	gate_hold_a:
	assert property (!o_gate_open && !i_scan_restart && !(take && op == OP_RELEASE)
		|=> !o_gate_open)
		else $error("gate reopened without release");
	gate_release_a:
	assert property (take && op == OP_RELEASE |=> o_gate_open)
		else $error("release did not open gate");
	jump_wait_a:
	assert property (take && op == OP_SKIP_START && i_instr.operand != SKIP_SHARED && !lit
		|=> o_busy && $stable(o_fetch_addr) ##1 !o_busy)
		else $error("numbered skip timing wrong");
	skip_pass_a:
	assert property (take && op == OP_SKIP_START && lit
		|=> !o_busy && o_fetch_addr == $past(o_fetch_addr) + PC_STEP)
		else $error("passed skip did not step");
	skip_quiet_a:
	assert property (o_busy && !i_scan_restart |=>
		$stable(o_temp_bits) && $stable(o_cond) && !o_exec.valid)
		else $error("state changed while skipping");

	// Main scenarios reached
	cover property (o_exec.valid && !o_exec.cond);
	cover property (take && op == OP_RELEASE && !o_gate_open);
	cover property (o_busy ##1 o_busy);
	cover property (take && op == OP_SKIP_START && !lit);

endmodule : lbf_flow_ctrl_checker

// >>> verification/lbf_flow_ctrl_tb.sv
/*
 * Self-checking testbench for the flow-control unit.
 * Assumes the package and the unit are compiled first; drives all ports itself.
 */
`timescale 1ns/1ps

module lbf_flow_ctrl_tb;
	import lbf_pkg::*;

	logic i_clk_sys = 1'b0;
	logic i_reset, i_scan_restart, i_instr_valid, i_tbl_we;
	lbf_instr_s i_instr;
	logic [SKIP_NW-1:0] i_tbl_num;
	logic [PROG_AW-1:0] i_tbl_addr, o_fetch_addr;
	logic o_cond, o_gate_open, o_busy, o_temp_reuse;
	lbf_exec_s o_exec;
	logic [TEMP_BITS-1:0] o_temp_bits;
	int num_errors = 0;
	int check_count = 0;

	lbf_flow_ctrl lbf_flow_ctrl_inst (.i_clk_sys, .i_reset, .i_scan_restart, .i_instr_valid,
		.i_instr, .i_tbl_we, .i_tbl_num, .i_tbl_addr, .o_fetch_addr, .o_cond, .o_gate_open,
		.o_busy, .o_exec, .o_temp_reuse, .o_temp_bits);

	// 50 MHz clock
	always #10 i_clk_sys = ~i_clk_sys;

	task chk(input string name, input logic [15:0] exp, input logic [15:0] got);
		check_count++;
		if (got !== exp) begin
			num_errors++;
			$display("FAIL %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	task test_done;
		$display("Checks %0d, errors %0d", check_count, num_errors);
		if (num_errors == 0 && check_count > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : test_done

	// Valid stays high so words run back to back; callers drop it before idling
	task step(input lbf_op_e op, input logic [6:0] opnd, input logic b);
		i_instr_valid = 1'b1;
		i_instr = '{op, opnd, b};
		@(posedge i_clk_sys);
		#1;
	endtask : step

	task right(input logic e);
		step(OP_RIGHT, 7'h00, 1'b0);
		chk("exec", {14'h0, 1'b1, e}, {14'h0, o_exec.valid, o_exec.cond});
	endtask : right

	task t_temp;
		chk("temp", TEMP_RESET, o_temp_bits);
		for (int k = 0; k < TEMP_BITS; k++) begin
			step(OP_LOAD_BIT, 7'h00, k[0]);
			step(OP_STORE_TEMP, k[6:0], 1'b0);
		end
		chk("temp", 16'h00AA, o_temp_bits);
		step(OP_LOAD_BIT, 7'h00, 1'b0);
		step(OP_LOAD_TEMP, 7'h03, 1'b0);
		chk("cond", 16'h0001, o_cond);
		step(OP_LOAD_BIT, 7'h00, 1'b0);
		step(OP_LOAD_TEMP, 7'h03, 1'b0);
		chk("cond", 16'h0001, o_cond);
		step(OP_STORE_TEMP, 7'h00, 1'b0);
		step(OP_STORE_TEMP, 7'h00, 1'b0);
		chk("reuse", 16'h0001, o_temp_reuse);
		step(OP_LOAD_BIT, 7'h00, 1'b1);
		step(OP_STORE_TEMP, 7'h00, 1'b0);
		chk("reuse", 16'h0000, o_temp_reuse);
	endtask : t_temp

	task t_gate;
		step(OP_LOAD_BIT, 7'h00, 1'b1);
		step(OP_GATE, 7'h00, 1'b0);
		chk("gate", 16'h0001, o_gate_open);
		step(OP_LOAD_BIT, 7'h00, 1'b1);
		right(1'b1);
		step(OP_LOAD_BIT, 7'h00, 1'b0);
		step(OP_GATE, 7'h00, 1'b0);
		chk("gate", 16'h0000, o_gate_open);
		step(OP_LOAD_BIT, 7'h00, 1'b1);
		right(1'b0);
		step(OP_LOAD_BIT, 7'h00, 1'b1);
		step(OP_GATE, 7'h00, 1'b0);
		chk("gate", 16'h0000, o_gate_open);
		step(OP_RELEASE, 7'h00, 1'b0);
		chk("gate", 16'h0001, o_gate_open);
		step(OP_LOAD_BIT, 7'h00, 1'b1);
		right(1'b1);
	endtask : t_gate

	// Lowest and highest numbered skips, each taken and then passed
	task t_jump;
		logic [6:0] n;
		logic [15:0] a, p;
		for (int i = 0; i < 2; i++) begin
			n = i ? SKIP_LAST : 7'h01;
			a = i ? 16'h0ABC : 16'h1234;
			i_instr_valid = 1'b0;
			i_tbl_we = 1'b1;
			i_tbl_num = n;
			i_tbl_addr = a;
			@(posedge i_clk_sys);
			#1;
			i_tbl_we = 1'b0;
			step(OP_LOAD_BIT, 7'h00, 1'b0);
			step(OP_SKIP_START, n, 1'b0);
			chk("busy", 16'h0001, o_busy);
			step(OP_RIGHT, 7'h00, 1'b0);
			chk("pc", a, o_fetch_addr);
			chk("exec", 16'h0000, o_exec.valid);
			step(OP_LOAD_BIT, 7'h00, 1'b1);
			p = o_fetch_addr;
			step(OP_SKIP_START, n, 1'b0);
			chk("pc", p + PC_STEP, o_fetch_addr);
		end
	endtask : t_jump

	// Shared skip with a second shared start and a foreign end inside
	task t_search;
		logic [15:0] p;
		logic [7:0] t;
		step(OP_LOAD_BIT, 7'h00, 1'b0);
		p = o_fetch_addr;
		t = o_temp_bits;
		step(OP_SKIP_START, SKIP_SHARED, 1'b0);
		step(OP_STORE_TEMP, 7'h01, 1'b0);
		step(OP_RIGHT, 7'h00, 1'b0);
		step(OP_SKIP_START, SKIP_SHARED, 1'b0);
		step(OP_SKIP_END, 7'h07, 1'b0);
		step(OP_SKIP_END, SKIP_SHARED, 1'b0);
		i_instr_valid = 1'b0;
		chk("pc", p + 16'h0006, o_fetch_addr);
		chk("busy", 16'h0000, o_busy);
		chk("temp", t, o_temp_bits);
	endtask : t_search

	// Scan restart with a closed gate: address back to zero, gate reopened
	task t_restart;
		step(OP_LOAD_BIT, 7'h00, 1'b0);
		step(OP_GATE, 7'h00, 1'b0);
		chk("gate", 16'h0000, o_gate_open);
		i_instr_valid = 1'b0;
		i_scan_restart = 1'b1;
		@(posedge i_clk_sys);
		#1;
		i_scan_restart = 1'b0;
		chk("pc", PC_RESET, o_fetch_addr);
		chk("gate", 16'h0001, o_gate_open);
		chk("busy", 16'h0000, o_busy);
	endtask : t_restart

	// Main sequence
	initial begin
		i_reset = 1'b1;
		i_scan_restart = 1'b0;
		i_instr_valid = 1'b0;
		i_instr = '0;
		i_tbl_we = 1'b0;
		i_tbl_num = '0;
		i_tbl_addr = '0;
		repeat (5) @(posedge i_clk_sys);
		#1;
		i_reset = 1'b0;
		t_temp;
		t_gate;
		t_jump;
		t_search;
		t_restart;
		test_done;
	end

	// Watchdog at 5000 cycles, well beyond the 64 or so cycles the tests need
	initial begin
		#100000;
		num_errors++;
		test_done;
	end

endmodule : lbf_flow_ctrl_tb

bind lbf_flow_ctrl lbf_flow_ctrl_checker lbf_flow_ctrl_checker_inst (.i_clk_sys, .i_reset,
	.i_scan_restart, .i_instr_valid, .i_instr, .o_fetch_addr, .o_cond, .o_gate_open,
	.o_busy, .o_exec, .o_temp_bits);
